//--- core/rsm_regs.svh
// Purpose: constants of the reference select monitor
// Assumes: included by bare name from the design files
// Notes: counts are in CLOCK_IN cycles, frequencies in kHz
// Operation
// - each input has priority 0..7; 0 only picked by a manual choice, 1 most preferred.
// - equal priorities resolve toward the lower input index.
// - auto revertive picks best qualified input and switches up at once.
// - auto non-revertive keeps current input until it turns invalid.
// - manual modes take the choice from a software field or a pin.
// - manual fallback moves to best valid input, else holdover or free-run.
// - manual holdover goes holdover or free-run, leaves when choice valid.
// - without hitless switching the full phase step reaches the output.
// - cancellation without slew limiting keeps the offset until the next switchover.
// - frequency-locked pairs (zero offset or integer related) get cancel.
// - slew limiting bleeds the offset by threshold steps per interval.
// - slew limits also cover lock entry and unlocked-pair switches.
// - pulse-per-second switches are hitless only with zero delay off.
// - oscillator loss clears only between 9 MHz and 160 MHz.
// - detector bypass makes oscillator valid, loss flag stays honest.
// - qualification needs flag-free full validation period; flag restarts.
// - a disabled monitor raises no flag and is ignored.
// - all enabled flags go to pins; selected-only flags to status.
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH

// --------------------------------------------------------------
// selection modes
// --------------------------------------------------------------
`define RSM_MODE_AUTO_REV 2'h0
`define RSM_MODE_AUTO_NREV 2'h1
`define RSM_MODE_MAN_FALL 2'h2
`define RSM_MODE_MAN_HOLD 2'h3

// --------------------------------------------------------------
// monitor flag field positions within one input's nibble
// --------------------------------------------------------------
`define RSM_MON_W 4
`define RSM_FLAG_FREQ 0
`define RSM_FLAG_MISS 1
`define RSM_FLAG_RUNT 2
`define RSM_FLAG_PHASE 3

// --------------------------------------------------------------
// sizes, limits and reset values
// --------------------------------------------------------------
`define RSM_NUM_REFS 2
`define RSM_PRIO_W 3
`define RSM_PRIO_OFF 3'h0
`define RSM_OSC_MIN_KHZ 18'h02328
`define RSM_OSC_MAX_KHZ 18'h27100
`define RSM_RST_SEL 1'h0
`define RSM_RST_ADJ 16'h0000

`endif

//--- core/rsm_pkg.sv
// Purpose: shared types of the reference select monitor
// Assumes: nothing beyond the constants header
// Notes: loop states are left to the tool to encode
package rsm_pkg;
  typedef enum logic [1:0] {RSM_FREE, RSM_HOLD, RSM_LOCK} rsm_loop_e;
  typedef logic [1:0] rsm_mode_t;
  typedef logic signed [15:0] rsm_phase_t;
endpackage : rsm_pkg

//--- core/rsm_ref_qualify.sv
// Purpose: qualification timer for one reference input
// Assumes: flags are synchronous to clk_in
// Notes: period 0 qualifies one cycle after the flags clear
`timescale 1ns/1ns
`default_nettype none
`include "rsm_regs.svh"
module rsm_ref_qualify #(
  parameter int CNT_W = 16
) (
  // clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // monitors
  input wire logic [`RSM_MON_W-1:0] flags_in,
  input wire logic [`RSM_MON_W-1:0] en_in,
  input wire logic [CNT_W-1:0] period_in,
  // results
  output logic qual_out,
  output logic [`RSM_MON_W-1:0] flags_out
);
  logic [CNT_W-1:0] cnt_reg;
  logic qual_reg;
  logic [`RSM_MON_W-1:0] flags_reg;
  logic [`RSM_MON_W-1:0] act_flags;
  logic any_flag;
  logic done;

  // --------------------------------------------------------------
  // flag gating
  // --------------------------------------------------------------
  // a disabled monitor is cut here so it can never disqualify
  assign act_flags = flags_in & en_in;
  assign any_flag = |act_flags;
  assign done = (cnt_reg >= period_in);

  // --------------------------------------------------------------
  // timer
  // --------------------------------------------------------------
  // counter saturates at the period so a long clean run never wraps
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
      qual_reg <= 1'b0;
      flags_reg <= '0;
    end else if (ce_in) begin
      flags_reg <= act_flags;
      if (any_flag) begin
        cnt_reg <= '0;
        qual_reg <= 1'b0;
      end else if (done) begin
        qual_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign qual_out = qual_reg;
  assign flags_out = flags_reg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_flag_restart: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) ce_in && any_flag |=> !qual_reg && cnt_reg == 0)
    else $error("flag did not restart qualification");
  a_qual_after_period: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    $rose(qual_reg) |-> $past(cnt_reg) >= $past(period_in) && !$past(any_flag))
    else $error("qualified before the validation period ran out");
  a_disabled_quiet: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    ce_in |=> (flags_reg & ~$past(en_in)) == '0)
    else $error("disabled monitor raised a flag");
  c_qualified: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(qual_reg));
endmodule : rsm_ref_qualify
`default_nettype wire

//--- core/rsm_select_top.sv
// Purpose: reference qualification, selection and hitless phase control
// Assumes: all inputs synchronous to CLOCK_IN, 25 MHz
// Notes: phase offsets are signed counts in one common unit
`timescale 1ns/1ns
`default_nettype none
`include "rsm_regs.svh"
module rsm_select_top
  import rsm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  // per-input monitors, input i in bits [4i+3:4i]
  input wire logic [2*`RSM_MON_W-1:0] MON_FLAGS_IN,
  input wire logic [2*`RSM_MON_W-1:0] MON_EN_IN,
  input wire logic [2*CNT_W-1:0] VALID_PERIOD_IN,
  input wire logic [2*`RSM_PRIO_W-1:0] PRIO_IN,
  // selection control
  input wire logic [1:0] MODE_IN,
  input wire logic MANUAL_REFERENCE_CHOICE_IN,
  input wire logic MAN_FROM_PIN_IN,
  input wire logic MAN_PIN_IN,
  input wire logic HISTORY_VALID_IN,
  // hitless switching control
  input wire logic HITLESS_EN_IN,
  input wire logic SLEW_LIMIT_ENABLE_IN,
  input wire logic [15:0] SLEW_STEP_THRESHOLD_IN,
  input wire logic [15:0] SLEW_STEP_INTERVAL_IN,
  input wire logic ZERO_DELAY_SYNC_IN,
  input wire logic PPS_MODE_IN,
  input wire logic PAIR_PPM_ZERO_IN,
  input wire logic PAIR_INT_RELATED_IN,
  input wire logic [15:0] PHASE_REF0_IN,
  input wire logic [15:0] PHASE_REF1_IN,
  // oscillator monitor
  input wire logic [17:0] OSC_FREQ_KHZ_IN,
  input wire logic OSC_DETECTOR_BYPASS_IN,
  // selection status
  output logic SEL_VALID_OUT,
  output logic SEL_REF_OUT,
  output logic HOLDOVER_OUT,
  output logic FREE_RUN_OUT,
  output logic [1:0] REF_QUAL_OUT,
  // monitor status
  output logic [2*`RSM_MON_W-1:0] REF_FLAGS_OUT,
  output logic [`RSM_MON_W-1:0] SEL_FLAGS_OUT,
  output logic OSC_INPUT_LOSS_FLAG_OUT,
  output logic OSC_VALID_OUT,
  // phase control
  output logic [15:0] PHASE_ADJ_OUT,
  output logic SLEW_ACTIVE_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  rsm_loop_e loop_reg, loop_next, fb_state;
  logic sel_reg, sel_next, valid_reg, hold_reg, free_reg;
  logic [`RSM_MON_W-1:0] sel_flags_reg, flags_sel_next;
  logic osc_loss_reg, osc_valid_reg, slew_act_reg, tick, osc_in_range;
  rsm_phase_t adj_reg, adj_next, phase_old, phase_new, adj_swap, adj_bled;
  logic [15:0] tmr_reg;
  logic [1:0] qual, cand;
  logic [`RSM_PRIO_W-1:0] prio0, prio1;
  logic pick1, any_cand, man_choice, man_ok, cur_ok;
  logic sw_evt, ref_swap, entry, pps_ok, freq_lock;
  logic cancel_swap, cancel_entry;
  logic signed [16:0] adj_ext;
  logic [16:0] mag, step;

  // --------------------------------------------------------------
  // per-input qualification
  // --------------------------------------------------------------
  // one timer per input; flags leave it registered for the pins
  genvar gi;
  generate
    for (gi = 0; gi < `RSM_NUM_REFS; gi++) begin : g_ref
      rsm_ref_qualify #(.CNT_W(CNT_W)) u_qual (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESET_N_IN),
        .ce_in(CLK_EN_IN),
        .flags_in(MON_FLAGS_IN[gi*`RSM_MON_W +: `RSM_MON_W]),
        .en_in(MON_EN_IN[gi*`RSM_MON_W +: `RSM_MON_W]),
        .period_in(VALID_PERIOD_IN[gi*CNT_W +: CNT_W]),
        .qual_out(qual[gi]),
        .flags_out(REF_FLAGS_OUT[gi*`RSM_MON_W +: `RSM_MON_W])
      );
      // priority 0 keeps an input out of every priority choice
      assign cand[gi] = qual[gi]
        && (PRIO_IN[gi*`RSM_PRIO_W +: `RSM_PRIO_W] != `RSM_PRIO_OFF);
    end
  endgenerate

  // --------------------------------------------------------------
  // priority decode
  // --------------------------------------------------------------
  // strict less-than lets input zero win every tie
  assign prio0 = PRIO_IN[0 +: `RSM_PRIO_W];
  assign prio1 = PRIO_IN[`RSM_PRIO_W +: `RSM_PRIO_W];
  assign pick1 = cand[1] && (!cand[0] || (prio1 < prio0));
  assign any_cand = |cand;
  assign man_choice = MAN_FROM_PIN_IN ? MAN_PIN_IN
    : MANUAL_REFERENCE_CHOICE_IN;
  assign man_ok = qual[man_choice];
  assign cur_ok = cand[sel_reg];
  assign fb_state = HISTORY_VALID_IN ? RSM_HOLD : RSM_FREE;

  // --------------------------------------------------------------
  // selection state machine
  // --------------------------------------------------------------
  // without a usable input the loop falls back and keeps its last index
  always_comb begin
    loop_next = fb_state;
    sel_next = sel_reg;
    case (MODE_IN)
      `RSM_MODE_AUTO_REV: begin
        if (any_cand) begin
          loop_next = RSM_LOCK;
          sel_next = pick1;
        end
      end
      `RSM_MODE_AUTO_NREV: begin
        if ((loop_reg == RSM_LOCK) && cur_ok) begin
          loop_next = RSM_LOCK;
        end else if (any_cand) begin
          loop_next = RSM_LOCK;
          sel_next = pick1;
        end
      end
      `RSM_MODE_MAN_FALL: begin
        if (man_ok) begin
          loop_next = RSM_LOCK;
          sel_next = man_choice;
        end else if (any_cand) begin
          loop_next = RSM_LOCK;
          sel_next = pick1;
        end
      end
      `RSM_MODE_MAN_HOLD: begin
        if (man_ok) begin
          loop_next = RSM_LOCK;
          sel_next = man_choice;
        end
      end
      default: begin
        loop_next = fb_state;
      end
    endcase
  end

  // --------------------------------------------------------------
  // switchover classification
  // --------------------------------------------------------------
  // zero delay sync breaks pps cancellation, so it falls back to a hit
  assign ref_swap = (loop_reg == RSM_LOCK) && (loop_next == RSM_LOCK)
    && (sel_next != sel_reg);
  assign entry = (loop_reg != RSM_LOCK) && (loop_next == RSM_LOCK);
  assign sw_evt = ref_swap || entry;
  assign pps_ok = !(PPS_MODE_IN && ZERO_DELAY_SYNC_IN);
  assign freq_lock = PAIR_PPM_ZERO_IN || PAIR_INT_RELATED_IN;
  assign cancel_swap = HITLESS_EN_IN && pps_ok && ref_swap
    && (freq_lock || SLEW_LIMIT_ENABLE_IN);
  assign cancel_entry = HITLESS_EN_IN && pps_ok && entry
    && SLEW_LIMIT_ENABLE_IN;
  assign phase_old = sel_reg ? PHASE_REF1_IN : PHASE_REF0_IN;
  assign phase_new = sel_next ? PHASE_REF1_IN : PHASE_REF0_IN;
  // build-out accumulates so a chain of switches stays hitless
  assign adj_swap = adj_reg + phase_old - phase_new;

  // --------------------------------------------------------------
  // slew limiter
  // --------------------------------------------------------------
  // magnitude is one bit wider so the most negative offset still bleeds
  assign adj_ext = {adj_reg[15], adj_reg};
  assign mag = adj_ext[16] ? 17'(-adj_ext) : 17'(adj_ext);
  assign step = (mag > {1'b0, SLEW_STEP_THRESHOLD_IN})
    ? {1'b0, SLEW_STEP_THRESHOLD_IN} : mag;
  assign adj_bled = adj_reg[15] ? adj_reg + step[15:0]
    : adj_reg - step[15:0];
  assign tick = (17'(tmr_reg) + 17'h00001)
    >= {1'b0, SLEW_STEP_INTERVAL_IN};

  // phase offset for the next cycle; a plain hit when cancel is off
  always_comb begin
    adj_next = adj_reg;
    if (sw_evt) begin
      if (cancel_swap) begin
        adj_next = adj_swap;
      end else if (cancel_entry) begin
        adj_next = -phase_new;
      end else begin
        adj_next = `RSM_RST_ADJ;
      end
    end else if (SLEW_LIMIT_ENABLE_IN && tick) begin
      adj_next = adj_bled;
    end
  end

  // --------------------------------------------------------------
  // oscillator monitor
  // --------------------------------------------------------------
  assign osc_in_range = (OSC_FREQ_KHZ_IN >= `RSM_OSC_MIN_KHZ)
    && (OSC_FREQ_KHZ_IN <= `RSM_OSC_MAX_KHZ);
  // flags of the input in use now; the next pick never carries a fault
  assign flags_sel_next = (loop_reg != RSM_LOCK) ? '0
    : REF_FLAGS_OUT[sel_reg*`RSM_MON_W +: `RSM_MON_W];

  // --------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      loop_reg <= RSM_FREE;
      sel_reg <= `RSM_RST_SEL;
      valid_reg <= 1'b0;
      hold_reg <= 1'b0;
      free_reg <= 1'b1;
    end else if (CLK_EN_IN) begin
      loop_reg <= loop_next;
      sel_reg <= sel_next;
      valid_reg <= (loop_next == RSM_LOCK);
      hold_reg <= (loop_next == RSM_HOLD);
      free_reg <= (loop_next == RSM_FREE);
    end
  end

  // phase and slew timer; timer restarts at each switchover
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      adj_reg <= `RSM_RST_ADJ;
      tmr_reg <= '0;
      slew_act_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      adj_reg <= adj_next;
      tmr_reg <= (sw_evt || tick || !SLEW_LIMIT_ENABLE_IN) ? '0
        : tmr_reg + 1'b1;
      slew_act_reg <= SLEW_LIMIT_ENABLE_IN && (adj_next != 0);
    end
  end

  // status flops; bypass changes validity, never the loss flag
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      osc_loss_reg <= 1'b1;
      osc_valid_reg <= 1'b0;
      sel_flags_reg <= '0;
    end else if (CLK_EN_IN) begin
      osc_loss_reg <= !osc_in_range;
      osc_valid_reg <= OSC_DETECTOR_BYPASS_IN || osc_in_range;
      sel_flags_reg <= flags_sel_next;
    end
  end

  assign SEL_VALID_OUT = valid_reg;
  assign SEL_REF_OUT = sel_reg;
  assign HOLDOVER_OUT = hold_reg;
  assign FREE_RUN_OUT = free_reg;
  assign REF_QUAL_OUT = qual;
  assign SEL_FLAGS_OUT = sel_flags_reg;
  assign OSC_INPUT_LOSS_FLAG_OUT = osc_loss_reg;
  assign OSC_VALID_OUT = osc_valid_reg;
  assign PHASE_ADJ_OUT = adj_reg;
  assign SLEW_ACTIVE_OUT = slew_act_reg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_prio_zero_excl: assert property (
    CLK_EN_IN && (MODE_IN == `RSM_MODE_AUTO_REV) && !any_cand
    |=> !valid_reg)
    else $error("excluded or unqualified input was selected");
  a_tie_low_wins: assert property (
    CLK_EN_IN && (MODE_IN == `RSM_MODE_AUTO_REV) && (&cand)
    && (prio0 == prio1) |=> valid_reg && !sel_reg)
    else $error("tie did not go to input zero");
  a_revert_best: assert property (
    CLK_EN_IN && (MODE_IN == `RSM_MODE_AUTO_REV) && any_cand
    |=> valid_reg && (sel_reg == $past(pick1)))
    else $error("revertive mode missed the best input");
  a_nonrev_keep: assert property (
    CLK_EN_IN && (MODE_IN == `RSM_MODE_AUTO_NREV) && valid_reg && cur_ok
    |=> valid_reg && $stable(sel_reg))
    else $error("non-revertive mode left a valid input");
  a_manual_pick: assert property (
    CLK_EN_IN && MODE_IN[1] && man_ok
    |=> valid_reg && (sel_reg == $past(man_choice)))
    else $error("manual choice not followed");
  a_fallback_state: assert property (
    CLK_EN_IN && !any_cand && !man_ok
    |=> !valid_reg && (hold_reg == $past(HISTORY_VALID_IN)) && (free_reg
      == !$past(HISTORY_VALID_IN)))
    else $error("wrong holdover or free-run fallback");
  a_mhold_no_move: assert property (
    CLK_EN_IN && (MODE_IN == `RSM_MODE_MAN_HOLD) && !man_ok |=> !valid_reg)
    else $error("manual holdover mode moved to another input");
  a_no_hitless: assert property (
    CLK_EN_IN && sw_evt && !HITLESS_EN_IN |=> adj_reg == 0)
    else $error("phase step absorbed with hitless off");
  a_buildout_held: assert property (
    CLK_EN_IN && !sw_evt && !SLEW_LIMIT_ENABLE_IN |=> $stable(adj_reg))
    else $error("build-out changed without slew limiting");
  a_zds_pps_hit: assert property (
    CLK_EN_IN && sw_evt && PPS_MODE_IN && ZERO_DELAY_SYNC_IN |=> adj_reg == 0)
    else $error("pps switch cancelled under zero delay sync");
  a_slew_step: assert property (
    CLK_EN_IN && !sw_evt && SLEW_LIMIT_ENABLE_IN && tick
    |=> (adj_reg == $past(adj_bled)) && ($past(step) <= {1'b0,
      $past(SLEW_STEP_THRESHOLD_IN)}))
    else $error("slew step exceeded its limit");
  a_osc_range: assert property (
    CLK_EN_IN |=> OSC_INPUT_LOSS_FLAG_OUT == !$past(osc_in_range))
    else $error("oscillator loss flag wrong");
  a_osc_bypass: assert property (
    CLK_EN_IN && OSC_DETECTOR_BYPASS_IN |=> osc_valid_reg)
    else $error("bypass did not force oscillator valid");
  a_sel_flags: assert property (
    CLK_EN_IN && (loop_reg != RSM_LOCK) |=> sel_flags_reg == '0)
    else $error("status flags shown with no selected input");
  c_revert_switch: cover property (valid_reg && $changed(sel_reg));
  c_holdover: cover property ($rose(hold_reg));
  c_slew_step: cover property (CLK_EN_IN && tick && adj_reg != 0);
  c_build_out: cover property (CLK_EN_IN && cancel_swap);
endmodule : rsm_select_top
`default_nettype wire

//--- dv/rsm_ref_source_model.sv
// Purpose: reference sources and host monitor setup for the selector
// Assumes: the bench changes the controls at the falling clock edge
// Notes: stray models raw detectors left running while disabled
`timescale 1ns/1ns
`default_nettype none
module rsm_ref_source_model (
  // scenario control
  input wire logic [1:0] fault_in,
  input wire logic [1:0] pps_in,
  input wire logic stray_in,
  // monitor levels toward the selector
  output logic [7:0] flags_out,
  output logic [7:0] en_out
);
  // ------------------------------------------------------------
  // host setup and raw detector levels
  // ------------------------------------------------------------
  // a pps input gets the phase-valid monitor alone, never with freq
  assign en_out = {pps_in[1] ? 4'h8 : 4'h7,
                   pps_in[0] ? 4'h8 : 4'h7};
  // disabled detectors still toggle, the selector must mask them
  assign flags_out = ({{4{fault_in[1]}}, {4{fault_in[0]}}} & en_out) |
                     ({8{stray_in}} & ~en_out);
endmodule : rsm_ref_source_model
`default_nettype wire

//--- dv/test_dpll_reference_select_monitor.sv
// Purpose: self-checking bench of the reference select monitor
// Assumes: inputs change at the falling edge of a 40 ns clock
// Notes: a row table covers the modes, hand tests cover the rest
`timescale 1ns/1ns
`default_nettype none
`include "rsm_regs.svh"
module test_dpll_reference_select_monitor
  import rsm_pkg::*;
;
  // --------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------
  typedef struct packed {
    rsm_mode_t mode;
    logic [5:0] prio;
    logic [1:0] fault;
    logic hist;
    logic from_pin;
    logic choice;
    logic [3:0] exp;
  } rsm_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] fault = 2'h0;
  logic [1:0] pps = 2'h0;
  logic stray = 1'b0;
  rsm_mode_t mode = 2'h0;
  logic [5:0] prio = 6'h0A;
  logic choice = 1'b0, from_pin = 1'b0, pin = 1'b0, hist = 1'b0;
  logic hitless = 1'b0, slew = 1'b0, zds = 1'b0, pps_m = 1'b0;
  logic ppm0 = 1'b0, intrel = 1'b0, byp = 1'b0, ce = 1'b1;
  logic [15:0] thr = 16'h0003, intv = 16'h0002;
  logic [15:0] ph0 = 16'h0000, ph1 = 16'h0005;
  logic [17:0] osc = 18'h02328;
  logic [7:0] flags, en, ref_flags;
  logic [3:0] sel_flags;
  logic [1:0] qual;
  logic [15:0] adj;
  logic sel_valid, sel_ref, hold, free, loss, osc_ok, slewing;
  int err_total = 0;
  int num_checks = 0;
  // prio is {input one, input zero}; exp is {locked, index, hold, free}
  rsm_row_s rows [15] = '{
    '{2'h0, 6'h0A, 2'h0, 1'b0, 1'b0, 1'b0, 4'hC},
    '{2'h0, 6'h09, 2'h0, 1'b0, 1'b0, 1'b0, 4'h8},
    '{2'h0, 6'h18, 2'h0, 1'b0, 1'b0, 1'b0, 4'hC},
    '{2'h1, 6'h19, 2'h0, 1'b0, 1'b0, 1'b0, 4'hC},
    '{2'h1, 6'h19, 2'h2, 1'b0, 1'b0, 1'b0, 4'h8},
    '{2'h0, 6'h00, 2'h0, 1'b1, 1'b0, 1'b0, 4'h2},
    '{2'h0, 6'h00, 2'h0, 1'b0, 1'b0, 1'b0, 4'h1},
    '{2'h3, 6'h00, 2'h0, 1'b0, 1'b0, 1'b1, 4'hC},
    '{2'h3, 6'h00, 2'h2, 1'b1, 1'b0, 1'b1, 4'h2},
    '{2'h3, 6'h00, 2'h0, 1'b1, 1'b0, 1'b1, 4'hC},
    '{2'h2, 6'h0A, 2'h0, 1'b0, 1'b1, 1'b0, 4'h8},
    '{2'h2, 6'h0A, 2'h1, 1'b0, 1'b1, 1'b0, 4'hC},
    '{2'h2, 6'h0A, 2'h3, 1'b0, 1'b1, 1'b0, 4'h1},
    '{2'h2, 6'h0A, 2'h3, 1'b1, 1'b1, 1'b0, 4'h2},
    '{2'h2, 6'h0A, 2'h0, 1'b0, 1'b1, 1'b0, 4'h8}};
  // {hitless, 0-ppm, integer related, pps, zero delay}
  logic [4:0] ph_cases [6] = '{5'h00, 5'h18, 5'h1B, 5'h1A, 5'h10, 5'h14};
  // {bypass, loss expected, valid expected, frequency in kHz}
  logic [20:0] osc_cases [5] = '{21'h082327, 21'h042328, 21'h067100,
                                 21'h0A7101, 21'h1C2327};

  // --------------------------------------------------------------
  // design, far side and clock
  // --------------------------------------------------------------
  rsm_select_top #(.CNT_W(16)) u_dut (
    .CLOCK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(ce),
    .MON_FLAGS_IN(flags), .MON_EN_IN(en),
    .VALID_PERIOD_IN({16'h0002, 16'h0002}), .PRIO_IN(prio),
    .MODE_IN(mode), .MANUAL_REFERENCE_CHOICE_IN(choice),
    .MAN_FROM_PIN_IN(from_pin), .MAN_PIN_IN(pin), .HISTORY_VALID_IN(hist),
    .HITLESS_EN_IN(hitless), .SLEW_LIMIT_ENABLE_IN(slew),
    .SLEW_STEP_THRESHOLD_IN(thr), .SLEW_STEP_INTERVAL_IN(intv),
    .ZERO_DELAY_SYNC_IN(zds), .PPS_MODE_IN(pps_m),
    .PAIR_PPM_ZERO_IN(ppm0), .PAIR_INT_RELATED_IN(intrel),
    .PHASE_REF0_IN(ph0), .PHASE_REF1_IN(ph1),
    .OSC_FREQ_KHZ_IN(osc), .OSC_DETECTOR_BYPASS_IN(byp),
    .SEL_VALID_OUT(sel_valid), .SEL_REF_OUT(sel_ref),
    .HOLDOVER_OUT(hold), .FREE_RUN_OUT(free), .REF_QUAL_OUT(qual),
    .REF_FLAGS_OUT(ref_flags), .SEL_FLAGS_OUT(sel_flags),
    .OSC_INPUT_LOSS_FLAG_OUT(loss), .OSC_VALID_OUT(osc_ok),
    .PHASE_ADJ_OUT(adj), .SLEW_ACTIVE_OUT(slewing));
  rsm_ref_source_model u_src (
    .fault_in(fault), .pps_in(pps), .stray_in(stray),
    .flags_out(flags), .en_out(en));
  // 25 MHz
  always #20 clk = ~clk;

  // --------------------------------------------------------------
  // compare and verdict
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // the sequence needs under 700 cycles, so a hang is cut at 3000
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic [15:0] exp_adj, old_ph;
    rsm_phase_t prev, want;
    logic cur;
    int gap;
    repeat (3) @(negedge clk);
    check({sel_valid, hold, free, loss, osc_ok, slewing, qual, adj},
          24'h300000);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      mode = rows[i].mode;
      prio = rows[i].prio;
      fault = rows[i].fault;
      hist = rows[i].hist;
      from_pin = rows[i].from_pin;
      pin = rows[i].choice;
      choice = rows[i].choice ^ rows[i].from_pin;
      repeat (10) @(negedge clk);
      check({sel_valid, sel_valid & sel_ref, hold, free}, rows[i].exp);
    end
    // one-cycle fault on the unselected input restarts its timer
    mode = 2'h0;
    from_pin = 1'b0;
    repeat (10) @(negedge clk);
    fault = 2'h1;
    @(negedge clk);
    fault = 2'h0;
    check({qual[0], ref_flags, sel_flags}, 13'h0070);
    repeat (2) @(negedge clk);
    check(qual[0], 1'b0);
    @(negedge clk);
    check(qual[0], 1'b1);
    stray = 1'b1;
    repeat (5) @(negedge clk);
    check({qual, ref_flags}, 10'h300);
    stray = 1'b0;
    // a fault on the selected input shows in status in the same cycle as the swap to input zero
    fault = 2'h2;
    @(negedge clk);
    fault = 2'h0;
    @(negedge clk);
    check({sel_flags, sel_ref}, 5'h0E);
    foreach (osc_cases[i]) begin
      {byp, osc} = {osc_cases[i][20], osc_cases[i][17:0]};
      repeat (3) @(negedge clk);
      check({loss, osc_ok}, osc_cases[i][19:18]);
    end
    // switches alternate the two inputs while locked
    exp_adj = 16'sh0000;
    cur = 1'b1;
    foreach (ph_cases[i]) begin
      {hitless, ppm0, intrel, pps_m, zds} = ph_cases[i];
      pps = {pps_m, pps_m};
      old_ph = cur ? ph1 : ph0;
      cur = ~cur;
      prio = cur ? 6'h0A : 6'h11;
      if (hitless && !(pps_m && zds) && (ppm0 || intrel)) begin
        exp_adj = exp_adj + old_ph - (cur ? ph1 : ph0);
      end else begin
        exp_adj = 16'sh0000;
      end
      repeat (6) @(negedge clk);
      check(adj, exp_adj);
    end
    repeat (30) @(negedge clk);
    check(adj, exp_adj);
    slew = 1'b1;
    prev = exp_adj;
    gap = 0;
    repeat (14) begin
      @(negedge clk);
      gap++;
      if (adj !== prev) begin
        want = (prev < 0) ? prev + ((prev < -3) ? 16'sd3 : -prev)
                          : prev - ((prev > 3) ? 16'sd3 : prev);
        check({gap > 1, adj}, {1'b1, want});
        prev = rsm_phase_t'(adj);
        gap = 0;
      end
    end
    check({slewing, adj}, 17'h0);
    // lock entry from free-run with slew on starts at minus new phase
    intv = 16'hFFFF;
    fault = 2'h3;
    repeat (8) @(negedge clk);
    fault = 2'h1;
    prio = 6'h0A;
    repeat (8) @(negedge clk);
    check({sel_valid, sel_ref, slewing, adj}, 19'h7FFFB);
    // a low clock enable freezes the loop through a double fault
    ce = 1'b0;
    fault = 2'h3;
    repeat (5) @(negedge clk);
    check({qual, sel_valid, adj}, 19'h5FFFB);
    give_verdict();
  end
endmodule : test_dpll_reference_select_monitor
`default_nettype wire
